// ===== hw/tsc_pkg.sv
// package of constants and types for the trace store controller state machine
package tsc_pkg;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 4;
  localparam int PTR_W = 4;
  localparam int DEPTH = 16;
  // register word offsets
  localparam logic [ADDR_W-1:0] OFF_CONTROL = 4'h0;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 4'h1;
  localparam logic [ADDR_W-1:0] OFF_MODE = 4'h2;
  localparam logic [ADDR_W-1:0] OFF_FLUSH_CTL = 4'h3;
  localparam logic [ADDR_W-1:0] OFF_READ_DATA = 4'h4;
  localparam logic [ADDR_W-1:0] OFF_READ_PTR = 4'h5;
  localparam logic [ADDR_W-1:0] OFF_PTR_ADVANCE = 4'h6;
  localparam logic [ADDR_W-1:0] OFF_CONFIG = 4'h7;
  // control_reg / status_reg field positions
  localparam int CTL_CAPTURE_BIT = 0;
  localparam int STS_IDLE_BIT = 0;
  localparam int STS_MEMORY_ERROR_FLAG_BIT = 1;
  localparam int STS_EMPTY_BIT = 2;
  localparam int STS_FULL_BIT = 3;
  localparam int STS_STATE_LSB = 4;
  // formatter_flush_control field positions
  localparam int FFC_STOP_AFTER_FLUSH = 0;
  localparam int FFC_MANUAL_FLUSH = 1;
  localparam int FFC_DRAIN_REQUEST = 2;
  // mode and configuration encodings
  localparam logic [1:0] MODE_CIRCULAR = 2'h0;
  localparam logic [1:0] MODE_SW_FIFO_ONE = 2'h1;
  localparam logic [1:0] MODE_HW_FIFO = 2'h2;
  localparam logic [1:0] MODE_SW_FIFO_TWO = 2'h3;
  localparam logic [1:0] CFG_LOCAL = 2'h0;
  localparam logic [1:0] CFG_FORWARD = 2'h1;
  localparam logic [1:0] CFG_SYSMEM = 2'h2;
  localparam logic [1:0] CFG_STREAM = 2'h3;
  localparam logic [DATA_W-1:0] NO_DATA = 32'h0fffffff;
  localparam logic [1:0] RESET_MODE = 2'h0;
  localparam logic [1:0] RESET_CFG = 2'h0;
  typedef enum logic [2:0] {
    ST_DISABLED, ST_RUNNING, ST_STOPPING, ST_DRAINING, ST_STOPPED, ST_DISABLING
  } tsc_state_t;
endpackage

// ===== hw/tsc_mem_if.sv
// carrier between controller and trace memory
`timescale 1ns/1ps
`default_nettype none
interface tsc_mem_if;
  import tsc_pkg::*;
  logic wr_en;
  logic [PTR_W-1:0] wr_addr;
  logic [DATA_W-1:0] wr_data;
  logic [PTR_W-1:0] rd_addr;
  logic [DATA_W-1:0] rd_data;
  modport ctl (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
  modport mem (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface
`default_nettype wire

// ===== hw/tsc_mem.sv
// small trace memory with registered read data
`timescale 1ns/1ps
`default_nettype none
module tsc_mem (
  input wire logic core_clk,
  tsc_mem_if.mem port
);
  import tsc_pkg::*;
  logic [DATA_W-1:0] store [DEPTH];
  always_ff @(posedge core_clk) begin
    if (port.wr_en) begin
      store[port.wr_addr] <= port.wr_data;
    end
    port.rd_data <= store[port.rd_addr];
  end
endmodule
`default_nettype wire

// ===== hw/tsc_ctrl.sv
// trace store controller: architectural state machine, trace buffer and register port
//
// Design decisions made here: the address map and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
//
// Contract
// [RULE_01] reset or clearing capture enable leads to disabled, idle flag set
// [RULE_02] mode and flush settings inert while disabled; buffer readable, manual pointer
// [RULE_03] enable set in disabled starts running; stop event moves to stopping
// [RULE_04] stopping drains pipeline and reports the same status as running
// [RULE_05] stopped reached only when pipeline, padding and write buffer empty
// [RULE_06] hardware fifo mode also needs fifo and unformatter empty
// [RULE_07] software fifo modes need room in fifo for pipeline residue
// [RULE_08] stream configuration stopping waits on stream receiver acceptance
// [RULE_09] forwarding configuration drains buffer out, then returns to stopped
// [RULE_10] stopped captures nothing; buffer readable in memory-backed configurations
// [RULE_11] drain request bit in stopped circular forwarding starts draining
// [RULE_12] stopped: fifo one readable by register, fifo two left in memory
// [RULE_13] clearing enable while stopped returns to disabled
// [RULE_14] streaming configurations give no trace reads over the register port
// [RULE_15] clearing enable in an active state enters disabling, never stopped
// [RULE_16] disabling does not empty hardware fifo; trace discarded
// [RULE_17] disabling exit waits on neither register reads nor forward port; outside hardware fifo mode an open forward beat still holds it
// [RULE_18] full fifo overwritten during disabling so stop completes
// [RULE_19] memory error in disabling or at hard stop: no writes, to disabled
// [RULE_20] a started transfer is never aborted; stall holds disabling
// [RULE_21] empty read returns no-data marker; also marks end of circular buffer
// [RULE_22] fifo two reads return marker; pointer advanced by advance register
// [RULE_23] completed flush with stop-after-flush raises stop event
// [RULE_24] one clock, one reset initialising interfaces and control registers
// [RULE_25] clearing enable during capture stops capture at once
// [RULE_26] idle flag derived from state: set only in disabled and stopped
// [RULE_27] drain request ignored outside stopped circular forwarding
module tsc_ctrl (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [tsc_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [tsc_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [tsc_pkg::DATA_W-1:0] reg_rdata,
  input wire logic trace_valid,
  input wire logic [tsc_pkg::DATA_W-1:0] trace_data,
  output logic trace_ready,
  input wire logic pipe_empty,
  input wire logic formatter_empty,
  input wire logic unformatter_empty,
  input wire logic flush_done,
  input wire logic mem_error,
  output logic fwd_valid,
  output logic [tsc_pkg::DATA_W-1:0] fwd_data,
  input wire logic fwd_ready,
  output logic strm_valid,
  output logic [tsc_pkg::DATA_W-1:0] strm_data,
  input wire logic strm_ready,
  output logic flush_request,
  output logic capture_active
);
  import tsc_pkg::*;

  tsc_state_t state;
  tsc_state_t next_state;
  logic capture_enable_bit;
  logic [1:0] mode;
  logic [1:0] config_sel;
  logic stop_after_flush;
  logic memory_error_flag;
  logic flush_pending;
  logic [PTR_W-1:0] wr_ptr;
  logic [PTR_W-1:0] rd_ptr;
  logic [PTR_W:0] level;
  logic rd_pending;
  logic out_busy;
  logic read_hit_pending;
  logic [DATA_W-1:0] rdata_mux;
  logic [PTR_W-1:0] next_rd_ptr;

  tsc_mem_if mem_bus ();
  tsc_mem u_mem (
    .core_clk(core_clk),
    .port(mem_bus)
  );

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
    return a == off;
  endfunction

  wire wr_ctl = reg_write && hit(reg_addr, OFF_CONTROL);
  wire wr_mode = reg_write && hit(reg_addr, OFF_MODE);
  wire wr_ffc = reg_write && hit(reg_addr, OFF_FLUSH_CTL);
  wire wr_rptr = reg_write && hit(reg_addr, OFF_READ_PTR);
  wire wr_adv = reg_write && hit(reg_addr, OFF_PTR_ADVANCE);
  wire wr_cfg = reg_write && hit(reg_addr, OFF_CONFIG);
  wire rd_data_req = reg_read && hit(reg_addr, OFF_READ_DATA);
  wire new_enable = wr_ctl ? reg_wdata[CTL_CAPTURE_BIT] : capture_enable_bit;

  wire idle_flag = (state == ST_DISABLED) || (state == ST_STOPPED); // RULE_26
  wire buf_empty = (level == '0);
  wire buf_full = (level == (PTR_W + 1)'(DEPTH));
  wire is_circ = (mode == MODE_CIRCULAR);
  wire is_hw = (mode == MODE_HW_FIFO);
  wire is_sw = (mode == MODE_SW_FIFO_ONE) || (mode == MODE_SW_FIFO_TWO);
  wire is_stream = (config_sel == CFG_STREAM) || (config_sel == CFG_SYSMEM && is_hw);
  // stream configuration always behaves as a circular buffer
  wire eff_circ = is_circ || (config_sel == CFG_STREAM);
  // register trace reads: only memory-backed, non-streaming, not fifo two
  wire reg_read_ok = !is_stream && (mode != MODE_SW_FIFO_TWO) && !out_busy; // RULE_14 RULE_22

  // capture only while running; writes overwrite oldest entry in circular mode
  wire capturing = (state == ST_RUNNING); // RULE_10 RULE_25
  wire room = !buf_full || eff_circ;
  // a word is taken only when offered and announced, so the source never loses one
  wire accept = capturing && trace_valid && trace_ready && room;
  // overwrite on full while disabling so the stop sequence can finish
  wire hard_overwrite = (state == ST_DISABLING) && buf_full; // RULE_18

  // stop event from a finished flush when configured
  wire stop_event = flush_pending && flush_done && stop_after_flush; // RULE_23

  // residue lands in the fifo only when there is space for it
  wire fifo_room = !buf_full; // RULE_07
  wire stop_done = pipe_empty && formatter_empty // RULE_05
    && (!is_hw || (unformatter_empty && buf_empty)) // RULE_06
    && (!is_sw || fifo_room)
    && (config_sel != CFG_STREAM || !strm_valid); // RULE_08
  wire drain_req = wr_ffc && reg_wdata[FFC_DRAIN_REQUEST] && (state == ST_STOPPED)
    && is_circ && (config_sel == CFG_FORWARD); // RULE_11 RULE_27
  // a transfer already offered, except a forward beat in hardware fifo mode, must complete before disabled is reached unless a memory error is flagged
  wire transfer_open = (fwd_valid && !fwd_ready && !is_hw) || (strm_valid && !strm_ready); // RULE_20
  wire disable_done = memory_error_flag || mem_error || !transfer_open; // RULE_17 RULE_19

  always_comb begin
    next_state = state;
    unique case (state)
      ST_DISABLED: if (new_enable) next_state = ST_RUNNING; // RULE_03
      ST_RUNNING: begin
        if (!new_enable) next_state = ST_DISABLING; // RULE_15 RULE_25
        else if (stop_event) next_state = ST_STOPPING; // RULE_03
      end
      ST_STOPPING: begin
        if (!new_enable) next_state = ST_DISABLING; // RULE_15
        else if (stop_done) next_state = ST_STOPPED; // RULE_04 RULE_05
      end
      ST_DRAINING: begin
        if (!new_enable) next_state = ST_DISABLING; // RULE_15
        else if (buf_empty && !fwd_valid) next_state = ST_STOPPED; // RULE_09
      end
      ST_STOPPED: begin
        if (!new_enable) next_state = ST_DISABLED; // RULE_13
        else if (drain_req) next_state = ST_DRAINING; // RULE_11
      end
      ST_DISABLING: if (disable_done) next_state = ST_DISABLED; // RULE_15 RULE_19
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state <= ST_DISABLED; // RULE_01 RULE_24
    end else begin
      state <= next_state;
    end
  end

  // configuration registers
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      capture_enable_bit <= 1'b0; // RULE_01
      mode <= RESET_MODE;
      config_sel <= RESET_CFG;
      stop_after_flush <= 1'b0;
    end else begin
      if (wr_ctl) capture_enable_bit <= reg_wdata[CTL_CAPTURE_BIT];
      // programming mode and configuration only takes hold while disabled
      if (wr_mode && state == ST_DISABLED) mode <= reg_wdata[1:0]; // RULE_02
      if (wr_cfg && state == ST_DISABLED) config_sel <= reg_wdata[1:0];
      if (wr_ffc) stop_after_flush <= reg_wdata[FFC_STOP_AFTER_FLUSH];
    end
  end

  // flush request: held until the sources answer or the state leaves running; set wins over clear
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      flush_pending <= 1'b0;
    end else if (wr_ffc && reg_wdata[FFC_MANUAL_FLUSH] && state == ST_RUNNING) begin
      flush_pending <= 1'b1;
    end else if (flush_done || state != ST_RUNNING) begin
      flush_pending <= 1'b0;
    end
  end

  // sticky memory error, cleared only by reset or a status write with the error bit zero, in any state
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      memory_error_flag <= 1'b0;
    end else if (mem_error) begin
      memory_error_flag <= 1'b1;
    end else if (reg_write && hit(reg_addr, OFF_STATUS) && !reg_wdata[STS_MEMORY_ERROR_FLAG_BIT]) begin
      memory_error_flag <= 1'b0;
    end
  end

  // buffer pointers and level
  wire pop_fwd = fwd_valid && fwd_ready && !rd_pending;
  wire pop_strm = strm_valid && strm_ready && !rd_pending;
  wire pop_reg = rd_data_req && reg_read_ok && !buf_empty && (mode != MODE_SW_FIFO_TWO);
  wire adv_two = wr_adv && (mode == MODE_SW_FIFO_TWO); // RULE_22
  // leaving disabling for disabled drops whatever remains in the fifo modes outside the stream configuration
  wire discard = (state == ST_DISABLING) && (next_state == ST_DISABLED) && !eff_circ; // RULE_16
  wire wr_do = accept && !(memory_error_flag || mem_error); // RULE_19
  wire overwrite = wr_do && buf_full;
  // hardware fifo empties over the forward port while running or stopping; disabling leaves it
  wire hw_out = is_hw && (config_sel == CFG_FORWARD)
    && (state == ST_RUNNING || state == ST_STOPPING); // RULE_06 RULE_16
  wire fetch = (state == ST_DRAINING || hw_out
    || (config_sel == CFG_STREAM && state != ST_DISABLED))
    && !buf_empty && !out_busy && !rd_pending;
  wire pop = pop_reg || fetch || (adv_two && !buf_empty) || overwrite || hard_overwrite;
  assign next_rd_ptr = wr_rptr ? reg_wdata[PTR_W-1:0] : rd_ptr + PTR_W'(pop); // RULE_02

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      level <= '0;
    end else if (discard) begin
      rd_ptr <= wr_ptr;
      level <= '0;
    end else begin
      if (wr_do) wr_ptr <= wr_ptr + PTR_W'(1);
      rd_ptr <= next_rd_ptr;
      if (wr_do && !pop) level <= level + (PTR_W + 1)'(1);
      else if (!wr_do && pop) level <= level - (PTR_W + 1)'(1);
    end
  end

  assign mem_bus.wr_en = wr_do;
  assign mem_bus.wr_addr = wr_ptr;
  assign mem_bus.wr_data = trace_data;
  assign mem_bus.rd_addr = rd_ptr;

  // forwarding and stream outputs fed from a one-deep output stage
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      rd_pending <= 1'b0;
      out_busy <= 1'b0;
      fwd_valid <= 1'b0;
      strm_valid <= 1'b0;
      fwd_data <= '0;
      strm_data <= '0;
    end else begin
      rd_pending <= fetch;
      if (rd_pending) begin
        out_busy <= 1'b1;
        fwd_valid <= (config_sel == CFG_FORWARD); // RULE_09
        strm_valid <= (config_sel == CFG_STREAM);
        fwd_data <= mem_bus.rd_data;
        strm_data <= mem_bus.rd_data;
      end else if (pop_fwd || pop_strm) begin
        out_busy <= 1'b0;
        fwd_valid <= 1'b0;
        strm_valid <= 1'b0;
      end
    end
  end

  // register reads: one cycle later
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      read_hit_pending <= 1'b0;
    end else begin
      read_hit_pending <= pop_reg;
    end
  end

  always_comb begin
    rdata_mux = '0;
    unique case (reg_addr)
      OFF_CONTROL: rdata_mux[CTL_CAPTURE_BIT] = capture_enable_bit;
      OFF_STATUS: begin
        rdata_mux[STS_IDLE_BIT] = idle_flag; // RULE_04
        rdata_mux[STS_MEMORY_ERROR_FLAG_BIT] = memory_error_flag;
        rdata_mux[STS_EMPTY_BIT] = buf_empty;
        rdata_mux[STS_FULL_BIT] = buf_full;
      end
      OFF_MODE: rdata_mux[1:0] = mode;
      OFF_FLUSH_CTL: rdata_mux[FFC_STOP_AFTER_FLUSH] = stop_after_flush;
      OFF_READ_PTR: rdata_mux[PTR_W-1:0] = rd_ptr;
      OFF_CONFIG: rdata_mux[1:0] = config_sel;
      default: rdata_mux = '0;
    endcase
  end

  logic [DATA_W-1:0] held_rdata;
  logic data_slot;
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      held_rdata <= '0;
      data_slot <= 1'b0;
    end else begin
      held_rdata <= reg_read ? rdata_mux : '0;
      data_slot <= rd_data_req;
    end
  end

  // an empty or refused data read answers with the marker
  always_comb begin
    if (data_slot) begin
      reg_rdata = read_hit_pending ? mem_bus.rd_data : NO_DATA; // RULE_21 RULE_12
    end else begin
      reg_rdata = held_rdata;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      trace_ready <= 1'b0;
      flush_request <= 1'b0;
      capture_active <= 1'b0;
    end else begin
      trace_ready <= (next_state == ST_RUNNING) && (eff_circ || level < (PTR_W + 1)'(DEPTH - 1));
      flush_request <= flush_pending;
      capture_active <= capture_enable_bit;
    end
  end
endmodule
`default_nettype wire

// ===== test/tsc_checker.sv
// concurrent checks on the trace store controller ports
`timescale 1ns/1ps
`default_nettype none
module tsc_checker (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [tsc_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [tsc_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [tsc_pkg::DATA_W-1:0] reg_rdata,
  input wire logic trace_ready,
  input wire logic flush_done,
  input wire logic fwd_valid,
  input wire logic [tsc_pkg::DATA_W-1:0] fwd_data,
  input wire logic fwd_ready,
  input wire logic strm_valid,
  input wire logic [tsc_pkg::DATA_W-1:0] strm_data,
  input wire logic strm_ready,
  input wire logic flush_request,
  input wire logic capture_active
);
  import tsc_pkg::*;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  wire ctl_wr = reg_write && reg_addr == OFF_CONTROL;
  property p_rst_quiet;
    disable iff (1'b0) sys_rst |=> !trace_ready && !capture_active && !fwd_valid
      && !strm_valid && !flush_request;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("outputs busy after reset");
  property p_cap_copy;
    ctl_wr |=> ##1 capture_active == $past(reg_wdata[CTL_CAPTURE_BIT], 2);
  endproperty
  a_cap_copy: assert property (p_cap_copy) else $error("enable not taken");
  property p_stop_now;
    ctl_wr && !reg_wdata[CTL_CAPTURE_BIT] |=> ##1 !trace_ready;
  endproperty
  a_stop_now: assert property (p_stop_now) else $error("capture kept after clear");
  property p_ready_en;
    trace_ready |=> capture_active;
  endproperty
  a_ready_en: assert property (p_ready_en) else $error("capture while disabled");
  property p_ctl_read;
    reg_read && reg_addr == OFF_CONTROL |=> reg_rdata[CTL_CAPTURE_BIT] == capture_active;
  endproperty
  a_ctl_read: assert property (p_ctl_read) else $error("control readback wrong");
  property p_fwd_hold;
    fwd_valid && !fwd_ready |=> fwd_valid && $stable(fwd_data);
  endproperty
  a_fwd_hold: assert property (p_fwd_hold) else $error("forward beat dropped");
  property p_strm_hold;
    strm_valid && !strm_ready |=> strm_valid && $stable(strm_data);
  endproperty
  a_strm_hold: assert property (p_strm_hold) else $error("stream beat dropped");
  property p_flush_end;
    flush_request && flush_done |-> ##[1:2] !flush_request;
  endproperty
  a_flush_end: assert property (p_flush_end) else $error("flush never ends");
  c_fwd: cover property (fwd_valid && fwd_ready);
  c_strm: cover property (strm_valid && strm_ready);
  c_flush: cover property (flush_request && flush_done);
endmodule
bind tsc_ctrl tsc_checker chk_u (.core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
  .trace_ready(trace_ready), .flush_done(flush_done), .fwd_valid(fwd_valid),
  .fwd_data(fwd_data), .fwd_ready(fwd_ready), .strm_valid(strm_valid), .strm_data(strm_data),
  .strm_ready(strm_ready), .flush_request(flush_request), .capture_active(capture_active));
`default_nettype wire

// ===== test/tsc_far_model.sv
// trace source, forward and stream sinks, and pipeline status around the controller
`timescale 1ns/1ps
`default_nettype none
module tsc_far_model (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic src_on,
  input wire logic stall,
  input wire logic hold_pipe,
  input wire logic hold_unf,
  input wire logic trace_ready,
  input wire logic flush_request,
  output var logic trace_valid,
  output var logic [tsc_pkg::DATA_W-1:0] trace_data,
  output var logic fwd_ready,
  output var logic strm_ready,
  output var logic flush_done,
  output logic pipe_empty,
  output logic formatter_empty,
  output logic unformatter_empty
);
  import tsc_pkg::*;
  integer seed = 32'ha896;
  logic [2:0] fl_cnt;
  initial begin
    trace_valid = 1'b0;
    trace_data = 32'h0;
    fwd_ready = 1'b0;
    strm_ready = 1'b0;
    flush_done = 1'b0;
    fl_cnt = 3'h4;
  end
  // residue stays in the pipeline while held
  assign pipe_empty = !hold_pipe;
  assign formatter_empty = !hold_pipe;
  assign unformatter_empty = !hold_unf;
  always @(posedge core_clk) begin
    // idle data lines change every cycle so a stale word is never read as valid
    if (sys_rst || !trace_valid || trace_ready) begin
      trace_valid <= src_on && !sys_rst;
      trace_data <= $random(seed);
    end
    // a stall lasts only as long as the surrounding system keeps it
    fwd_ready <= !stall && $random(seed) % 2 == 0;
    strm_ready <= !stall && $random(seed) % 2 == 0;
    fl_cnt <= !flush_request ? 3'h4 : (fl_cnt != 3'h0 ? fl_cnt - 3'h1 : 3'h0);
    flush_done <= flush_request && fl_cnt == 3'h1;
  end
endmodule
`default_nettype wire

// ===== test/tb_top.sv
// self-checking bench for the trace store controller
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import tsc_pkg::*;
  typedef struct packed {logic [DATA_W-1:0] v; logic [DATA_W-1:0] m;} tsc_exp_t;
  logic core_clk = 1'b0, sys_rst = 1'b1, reg_write = 1'b0, reg_read = 1'b0, mem_error = 1'b0;
  logic src_on = 1'b0, stall = 1'b0, hold_pipe = 1'b0, hold_unf = 1'b0, rd_seen = 1'b0;
  logic [ADDR_W-1:0] reg_addr = 4'h0;
  logic [DATA_W-1:0] reg_wdata = 32'h0, reg_rdata, trace_data, fwd_data, strm_data, last;
  logic trace_valid, trace_ready, pipe_empty, formatter_empty, unformatter_empty, flush_done;
  logic fwd_valid, fwd_ready, strm_valid, strm_ready, flush_request, capture_active;
  int fails = 0, total_checks = 0, cyc = 0, fwd_cnt = 0;
  tsc_exp_t exq[$];
  tsc_exp_t x;
  tsc_ctrl dut_u (.core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .trace_valid(trace_valid), .trace_data(trace_data), .trace_ready(trace_ready),
    .pipe_empty(pipe_empty), .formatter_empty(formatter_empty),
    .unformatter_empty(unformatter_empty), .flush_done(flush_done), .mem_error(mem_error),
    .fwd_valid(fwd_valid), .fwd_data(fwd_data), .fwd_ready(fwd_ready), .strm_valid(strm_valid),
    .strm_data(strm_data), .strm_ready(strm_ready), .flush_request(flush_request),
    .capture_active(capture_active));
  tsc_far_model far_u (.core_clk(core_clk), .sys_rst(sys_rst), .src_on(src_on), .stall(stall),
    .hold_pipe(hold_pipe), .hold_unf(hold_unf), .trace_ready(trace_ready),
    .flush_request(flush_request), .trace_valid(trace_valid), .trace_data(trace_data),
    .fwd_ready(fwd_ready), .strm_ready(strm_ready), .flush_done(flush_done),
    .pipe_empty(pipe_empty), .formatter_empty(formatter_empty),
    .unformatter_empty(unformatter_empty));
  always #2 core_clk = ~core_clk;
  task automatic end_of_test();
    if (fails == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic cmp(input logic [DATA_W-1:0] g, input logic [DATA_W-1:0] e);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic chk(input logic g, input logic e);
    cmp({31'h0, g}, {31'h0, e});
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge core_clk);
    reg_write <= 1'b0;
  endtask
  // mask zero marks a poll read whose value only steers the sequence
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e, m);
    exq.push_back('{e, m});
    @(posedge core_clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge core_clk);
    reg_read <= 1'b0;
    @(negedge core_clk);
    last = reg_rdata;
  endtask
  task automatic poll(input logic [1:0] md);
    for (int i = 0; i < 300; i++) begin
      if (md == MODE_SW_FIFO_ONE) rd(OFF_READ_DATA, 32'h0, 32'h0);
      rd(OFF_STATUS, 32'h0, 32'h0);
      if (last[STS_IDLE_BIT] === 1'b1) break;
    end
    cmp({31'h0, last[STS_IDLE_BIT]}, 32'h1);
  endtask
  task automatic sess(input logic [1:0] cfg, input logic [1:0] md, input bit emg);
    bit fwd_drain;
    fwd_drain = cfg == CFG_FORWARD && md == MODE_CIRCULAR;
    wr(OFF_MODE, {30'h0, md});
    wr(OFF_CONFIG, {30'h0, cfg});
    wr(OFF_FLUSH_CTL, 32'h1 << FFC_STOP_AFTER_FLUSH);
    chk(flush_request, 1'b0);
    wr(OFF_CONTROL, 32'h1);
    rd(OFF_STATUS, 32'h0, 32'h1);
    wr(OFF_MODE, {30'h0, ~md});
    rd(OFF_MODE, {30'h0, md}, 32'h3);
    // stalled sinks keep a beat open until the stop checks have run
    stall <= 1'b1;
    src_on <= 1'b1;
    repeat (8) @(posedge core_clk);
    src_on <= 1'b0;
    if (cfg == CFG_STREAM || md == MODE_SW_FIFO_TWO) rd(OFF_READ_DATA, NO_DATA, '1);
    if (emg) begin
      @(posedge core_clk);
      mem_error <= 1'b1;
      @(posedge core_clk);
      mem_error <= 1'b0;
      wr(OFF_CONTROL, 32'h0);
      repeat (2) @(negedge core_clk);
      chk(capture_active, 1'b0);
      poll(md);
      rd(OFF_STATUS, 32'h2, 32'h2);
      wr(OFF_STATUS, 32'h0);
      rd(OFF_STATUS, 32'h0, 32'h2);
      return;
    end
    stall <= 1'b1;
    hold_pipe <= 1'b1;
    hold_unf <= 1'b1;
    wr(OFF_FLUSH_CTL, 32'h3);
    repeat (40) @(posedge core_clk);
    rd(OFF_STATUS, 32'h0, 32'h1);
    hold_pipe <= 1'b0;
    repeat (40) @(posedge core_clk);
    if (md == MODE_HW_FIFO || cfg == CFG_STREAM) rd(OFF_STATUS, 32'h0, 32'h1);
    stall <= 1'b0;
    hold_unf <= 1'b0;
    poll(md);
    chk(trace_ready, 1'b0);
    rd(OFF_CONTROL, 32'h1, 32'h1);
    stall <= 1'b1;
    fwd_cnt = 0;
    wr(OFF_FLUSH_CTL, 32'h1 << FFC_DRAIN_REQUEST);
    rd(OFF_STATUS, {31'h0, !fwd_drain}, 32'h1);
    stall <= 1'b0;
    poll(md);
    if (fwd_drain) chk(fwd_cnt != 0, 1'b1);
    wr(OFF_CONTROL, 32'h0);
    poll(md);
    rd(OFF_CONTROL, 32'h0, 32'h1);
  endtask
  always @(posedge core_clk) begin
    rd_seen <= reg_read;
    if (fwd_valid === 1'b1 && fwd_ready === 1'b1) fwd_cnt++;
    cyc++;
    if (cyc == 60000) begin
      fails++;
      end_of_test();
    end
  end
  always @(negedge core_clk) begin
    if (rd_seen && exq.size() != 0) begin
      x = exq.pop_front();
      if (x.m != 32'h0) cmp(reg_rdata & x.m, x.v & x.m);
    end
  end
  initial begin
    repeat (10) @(posedge core_clk);
    sys_rst <= 1'b0;
    rd(OFF_CONTROL, 32'h0, 32'h1);
    rd(OFF_STATUS, 32'h1, 32'h1);
    rd(4'h9, 32'h0, '1);
    sess(CFG_LOCAL, MODE_CIRCULAR, 1'b0);
    sess(CFG_FORWARD, MODE_CIRCULAR, 1'b0);
    sess(CFG_FORWARD, MODE_HW_FIFO, 1'b0);
    sess(CFG_LOCAL, MODE_SW_FIFO_ONE, 1'b0);
    sess(CFG_SYSMEM, MODE_SW_FIFO_TWO, 1'b0);
    sess(CFG_STREAM, MODE_CIRCULAR, 1'b0);
    sess(CFG_LOCAL, MODE_CIRCULAR, 1'b1);
    // open stream beat under stall keeps the emergency stop waiting
    wr(OFF_CONFIG, {30'h0, CFG_STREAM});
    stall <= 1'b1;
    wr(OFF_CONTROL, 32'h1);
    src_on <= 1'b1;
    for (int i = 0; i < 50 && strm_valid !== 1'b1; i++) @(posedge core_clk);
    src_on <= 1'b0;
    wr(OFF_CONTROL, 32'h0);
    repeat (20) @(posedge core_clk);
    rd(OFF_STATUS, 32'h0, 32'h1);
    stall <= 1'b0;
    poll(MODE_CIRCULAR);
    rd(OFF_CONTROL, 32'h0, 32'h1);
    end_of_test();
  end
endmodule
`default_nettype wire
